// *** csl_pkg.sv ***
// Purpose: Shared constants for the configuration strap latch.
// Assumes: AXI4-Lite register access with 32-bit data, one word per register.
// Notes: Offsets are byte addresses of aligned words.
package csl_pkg;
    localparam logic [7:0] ADDR_STRAP_STATUS = 8'h00;
    localparam logic [7:0] ADDR_INDICATOR_CFG = 8'h04;
    localparam logic [7:0] ADDR_TARGET_ADDR = 8'h08;
    localparam logic [7:0] ADDR_PTP_CTL = 8'h0C;
    localparam logic [7:0] ADDR_HARDWARE_CONFIG_REG = 8'h10;
    localparam logic [7:0] ADDR_RESET_CONTROL_REG = 8'h14;
    localparam logic [7:0] ADDR_EEPROM_CMD = 8'h18;
    localparam logic [7:0] ADDR_PHY_XOVER = 8'h1C;
    localparam logic [7:0] ADDR_EE_WORD = 8'h20;
    // Reset values of soft straps without a pin.
    localparam logic [5:0] IND_EN_DEFAULT = 6'h3F;
    localparam logic [2:0] IND_FN_DEFAULT = 3'h0;
    localparam logic ADDR_OVR_DEFAULT = 1'b0;
    localparam logic [6:0] TGT_ADDR_DEFAULT = 7'h0A;
    localparam logic AUTO_XOVER_DEFAULT = 1'b1;
    localparam logic MANUAL_XOVER_DEFAULT = 1'b0;
    // Built-in serial target address used while override is clear; value is arbitrary.
    localparam logic [6:0] TGT_ADDR_BUILTIN = 7'h2A;
    // Field positions.
    localparam int IND_EN_LSB = 0;
    localparam int IND_FN_LSB = 8;
    localparam int TGT_ADDR_LSB = 0;
    localparam int ADDR_OVR_BIT = 8;
    localparam int PTP_EN_BIT = 0;
    localparam int HW_XOVER_BIT = 1;
    localparam int HW_READY_BIT = 27;
    localparam int XOVER_CTRL_BIT = 0;
    localparam int XOVER_FX_BIT = 1;
    localparam int DIG_RST_BIT = 0;
    localparam int EE_RELOAD_BIT = 0;
    localparam int EE_DONE_BIT = 1;
    localparam int EE_VALID_BIT = 2;
    localparam int EE_PRESENT_BIT = 3;
    // Loader restart cycles while ready is held low.
    localparam logic [3:0] LOAD_CYCLES = 4'h8;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage : csl_pkg

// *** csl_sync.sv ***
// Purpose: Two-flop synchroniser for strap pins.
// Assumes: Pin inputs are asynchronous to aclk.
// Notes: Stage one is read only by stage two.
`timescale 1ns/10ps
module csl_sync #(
    parameter int W = 1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s1_q <= '0;
            s2_q <= '0;
        end
        else
        begin
            s1_q <= din;
            s2_q <= s1_q;
        end
    end
    assign dout = s2_q;
endmodule : csl_sync

// *** csl_strap_latch.sv ***
// What this block does
// - Capture hard and soft straps at reset.
// - Loader overrides soft straps; hard straps fixed.
// - Sample at reset release; EEPROM replaces.
// - Pinless soft straps take tie-off constants.
// - Reset/reload restores latched values without EEPROM.
// - Digital reset or reload never resamples pins.
// - Configure loads bit; affect combines conditions.
// - Indicator enable field defaults all ones.
// - Indicator function field defaults all zeros.
// - Override set: target uses strap address.
// - Strap address default 0001010b, override only.
// - PTP enable loaded from dedicated pin.
// - PTP defaults give transparent clock.
// - Crossover strap state bit defaults one.
// - Strap mode: crossover from both straps.
// - Manual strap: 0 straight, 1 crossed.
// - Crossover straps ignored in fibre mode.
// - Reload restarts loader, holds ready low.
// Purpose: Latches configuration straps and seeds register defaults.
// Assumes: pin_resetn and strap pins are asynchronous; the loader presents whole words.
// Notes: Registers reached over AXI4-Lite.
//
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
module csl_strap_latch (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pin_resetn,
    input wire logic ptp_enable_pin,
    input wire logic hard_strap_pin,
    input wire logic ee_load_valid,
    input wire logic [17:0] ee_load_word,
    input wire logic ee_present,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic device_ready,
    output logic [6:0] target_addr,
    output logic crossover_mdix
);
    typedef enum logic [2:0] {
        CSL_IDLE = 3'b001,
        CSL_LOAD = 3'b010,
        CSL_RUN = 3'b100
    } csl_state_t;

    logic [1:0] pins_s;
    logic prst_s;
    csl_sync #(.W(3)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .din({pin_resetn, ptp_enable_pin, hard_strap_pin}),
        .dout({prst_s, pins_s})
    );

    // Soft strap layout: en[5:0], fn[8:6], addr[15:9], ovr[16], auto[17]; manual is hardwired below.
    logic [17:0] latched_q, latched_d;
    logic [17:0] soft_q, soft_d;
    logic ptp_latch_q, ptp_latch_d;
    logic hard_q, hard_d;
    logic manual_q, manual_d;
    logic prst_prev_q, prst_prev_d;
    logic capture_q, capture_d;
    csl_state_t st_q, st_d;
    logic [3:0] cnt_q, cnt_d;
    logic ready_q, ready_d;
    logic [6:0] tgt_q, tgt_d;
    logic mdix_q, mdix_d;
    logic ptp_en_q, ptp_en_d;
    logic [5:0] ind_en_q, ind_en_d;
    logic [2:0] ind_fn_q, ind_fn_d;
    logic xctrl_q, xctrl_d;
    logic fx_q, fx_d;
    logic ee_valid_q, ee_valid_d;

    logic aw_held_q, aw_held_d;
    logic w_held_q, w_held_d;
    logic [7:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    logic arready_q, arready_d;
    // Ready flops mirror the free holding slots, so the ready pins come straight from registers.
    logic awready_q;
    logic wready_q;

    function automatic logic [17:0] tie_off();
        tie_off = {csl_pkg::AUTO_XOVER_DEFAULT, csl_pkg::ADDR_OVR_DEFAULT,
                   csl_pkg::TGT_ADDR_DEFAULT, csl_pkg::IND_FN_DEFAULT, csl_pkg::IND_EN_DEFAULT};
    endfunction : tie_off

    logic do_write;
    logic restart;
    logic pin_release;
    assign do_write = aw_held_q && w_held_q && !bvalid_q;
    assign pin_release = prst_s && !prst_prev_q;

    always_comb
    begin
        prst_prev_d = prst_s;
        capture_d = 1'b0;
        latched_d = latched_q;
        ptp_latch_d = ptp_latch_q;
        hard_d = hard_q;
        manual_d = manual_q;
        // Capture happens on the first clock after aresetn releases, the third after pin_resetn releases.
        if (pin_release || capture_q)
        begin
            latched_d = tie_off();
            ptp_latch_d = pins_s[1];
            hard_d = pins_s[0];
            manual_d = csl_pkg::MANUAL_XOVER_DEFAULT;
        end
    end

    always_comb
    begin
        restart = 1'b0;
        if (do_write && awaddr_q == csl_pkg::ADDR_RESET_CONTROL_REG && wstrb_q[0] && wdata_q[csl_pkg::DIG_RST_BIT])
        begin
            restart = 1'b1;
        end
        if (do_write && awaddr_q == csl_pkg::ADDR_EEPROM_CMD && wstrb_q[0] && wdata_q[csl_pkg::EE_RELOAD_BIT])
        begin
            restart = 1'b1;
        end
    end

    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_q;
        ready_d = ready_q;
        soft_d = soft_q;
        ee_valid_d = ee_valid_q;
        ptp_en_d = ptp_en_q;
        xctrl_d = xctrl_q;
        fx_d = fx_q;
        case (st_q)
            CSL_IDLE:
            begin
                if (capture_q || pin_release)
                begin
                    st_d = CSL_LOAD;
                    cnt_d = '0;
                end
            end
            CSL_LOAD:
            begin
                ready_d = 1'b0;
                if (cnt_q == 4'h0)
                begin
                    // Restore un-overridden values; pins are not resampled here.
                    soft_d = latched_q;
                    ptp_en_d = ptp_latch_q;
                    ee_valid_d = 1'b0;
                end
                if (ee_present && ee_load_valid)
                begin
                    soft_d = ee_load_word;
                    ee_valid_d = 1'b1;
                end
                cnt_d = cnt_q + 4'h1;
                if (cnt_q == csl_pkg::LOAD_CYCLES - 4'h1)
                begin
                    st_d = CSL_RUN;
                    ready_d = 1'b1;
                end
            end
            CSL_RUN:
            begin
                if (do_write && awaddr_q == csl_pkg::ADDR_PHY_XOVER && wstrb_q[0])
                begin
                    xctrl_d = wdata_q[csl_pkg::XOVER_CTRL_BIT];
                    fx_d = wdata_q[csl_pkg::XOVER_FX_BIT];
                end
                if (do_write && awaddr_q == csl_pkg::ADDR_PTP_CTL && wstrb_q[0])
                begin
                    ptp_en_d = wdata_q[csl_pkg::PTP_EN_BIT];
                end
            end
            default:
            begin
                st_d = CSL_IDLE;
            end
        endcase
        if (restart || pin_release)
        begin
            st_d = CSL_LOAD;
            cnt_d = '0;
            ready_d = 1'b0;
        end
    end

    always_comb
    begin
        ind_en_d = soft_q[5:0];
        ind_fn_d = soft_q[8:6];
        tgt_d = soft_q[16] ? soft_q[15:9] : csl_pkg::TGT_ADDR_BUILTIN;
        mdix_d = mdix_q;
        if (fx_q)
        begin
            mdix_d = 1'b0;
        end
        else if (xctrl_q)
        begin
            mdix_d = soft_q[17] ? mdix_q : manual_q;
        end
    end

    always_comb
    begin
        aw_held_d = aw_held_q;
        w_held_d = w_held_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        if (s_axi_awvalid && awready_q)
        begin
            aw_held_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q)
        begin
            w_held_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        if (do_write)
        begin
            bvalid_d = 1'b1;
            bresp_d = (awaddr_q <= csl_pkg::ADDR_EE_WORD && awaddr_q[1:0] == 2'h0) ? csl_pkg::AXI_OKAY
                : csl_pkg::AXI_SLVERR;
        end
        if (bvalid_q && s_axi_bready)
        begin
            bvalid_d = 1'b0;
            aw_held_d = 1'b0;
            w_held_d = 1'b0;
        end
    end

    always_comb
    begin
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        arready_d = !rvalid_q && !arready_q;
        if (s_axi_arvalid && arready_q)
        begin
            arready_d = 1'b0;
            rvalid_d = 1'b1;
            rresp_d = csl_pkg::AXI_OKAY;
            rdata_d = 32'h0000_0000;
            case (s_axi_araddr)
                csl_pkg::ADDR_STRAP_STATUS: rdata_d = {13'h0000, st_q, hard_q, manual_q, latched_q[17:4]};
                csl_pkg::ADDR_INDICATOR_CFG:
                    rdata_d = {21'h00_0000, ind_fn_q, 2'h0, ind_en_q};
                csl_pkg::ADDR_TARGET_ADDR: rdata_d = {23'h00_0000, soft_q[16], 1'b0, tgt_q};
                csl_pkg::ADDR_PTP_CTL: rdata_d = {31'h0000_0000, ptp_en_q};
                csl_pkg::ADDR_HARDWARE_CONFIG_REG:
                    rdata_d = {4'h0, ready_q, 25'h000_0000, soft_q[17], hard_q};
                csl_pkg::ADDR_EEPROM_CMD:
                    rdata_d = {28'h000_0000, ee_present, ee_valid_q, ready_q, st_q == CSL_LOAD};
                csl_pkg::ADDR_PHY_XOVER: rdata_d = {29'h0000_0000, mdix_q, fx_q, xctrl_q};
                csl_pkg::ADDR_RESET_CONTROL_REG: rdata_d = 32'h0000_0000;
                default: rresp_d = csl_pkg::AXI_SLVERR;
            endcase
        end
        if (rvalid_q && s_axi_rready)
        begin
            rvalid_d = 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            prst_prev_q <= 1'b0;
            capture_q <= 1'b1;
            latched_q <= '0;
            soft_q <= '0;
            ptp_latch_q <= 1'b0;
            hard_q <= 1'b0;
            manual_q <= 1'b0;
            st_q <= CSL_IDLE;
            cnt_q <= '0;
            ready_q <= 1'b0;
            tgt_q <= '0;
            mdix_q <= 1'b0;
            ptp_en_q <= 1'b0;
            ind_en_q <= '0;
            ind_fn_q <= '0;
            xctrl_q <= 1'b0;
            fx_q <= 1'b0;
            ee_valid_q <= 1'b0;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            bvalid_q <= 1'b0;
            bresp_q <= '0;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= '0;
            arready_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
        end
        else
        begin
            prst_prev_q <= prst_prev_d;
            capture_q <= capture_d;
            latched_q <= latched_d;
            soft_q <= soft_d;
            ptp_latch_q <= ptp_latch_d;
            hard_q <= hard_d;
            manual_q <= manual_d;
            st_q <= st_d;
            cnt_q <= cnt_d;
            ready_q <= ready_d;
            tgt_q <= tgt_d;
            mdix_q <= mdix_d;
            ptp_en_q <= ptp_en_d;
            ind_en_q <= ind_en_d;
            ind_fn_q <= ind_fn_d;
            xctrl_q <= xctrl_d;
            fx_q <= fx_d;
            ee_valid_q <= ee_valid_d;
            aw_held_q <= aw_held_d;
            w_held_q <= w_held_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            arready_q <= arready_d;
            awready_q <= !aw_held_d;
            wready_q <= !w_held_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign device_ready = ready_q;
    assign target_addr = tgt_q;
    assign crossover_mdix = mdix_q;

    chk_reload_ready_low: assert property (@(posedge aclk) disable iff (!aresetn)
        restart |=> !ready_q [*8]) else $error("ready not held low after reload");
    chk_target_builtin: assert property (@(posedge aclk) disable iff (!aresetn)
        aresetn && !soft_q[16] |=> tgt_q == csl_pkg::TGT_ADDR_BUILTIN) else $error("builtin address not used");
    chk_target_override: assert property (@(posedge aclk) disable iff (!aresetn)
        soft_q[16] |=> tgt_q == $past(soft_q[15:9])) else $error("override address not used");
    chk_restore_latched: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_q == CSL_LOAD && cnt_q == 4'h0 && !(ee_present && ee_load_valid) && !restart && !pin_release)
        |=> soft_q == $past(latched_q)) else $error("latched values not restored");
    chk_hard_fixed: assert property (@(posedge aclk) disable iff (!aresetn)
        (!pin_release && !capture_q) |=> $stable(hard_q)) else $error("hard strap changed");
    chk_fibre_mdix: assert property (@(posedge aclk) disable iff (!aresetn)
        fx_q |=> !mdix_q) else $error("crossover active in fibre mode");
    chk_manual_xover: assert property (@(posedge aclk) disable iff (!aresetn)
        (xctrl_q && !fx_q && !soft_q[17]) |=> mdix_q == $past(manual_q)) else $error("manual strap ignored");
    chk_indicator_load: assert property (@(posedge aclk) disable iff (!aresetn)
        1'b1 |=> ind_en_q == $past(soft_q[5:0]) && ind_fn_q == $past(soft_q[8:6]))
        else $error("indicator field not loaded");
endmodule : csl_strap_latch

// *** csl_board_model.sv ***
// Purpose: Board strap pins and EEPROM loader that face the strap latch.
// Assumes: The bench changes its commands just after a rising edge of aclk.
// Notes: The loader word is inverted whenever it is not valid, so stale data cannot pass for a load.
`timescale 1ns/10ps
module csl_board_model (
    input wire logic aclk,
    input wire logic device_ready,
    input wire logic ptp_level,
    input wire logic hard_level,
    input wire logic ee_attached,
    input wire logic [17:0] ee_image,
    input wire logic rst_req,
    output logic pin_resetn,
    output logic ptp_enable_pin,
    output logic hard_strap_pin,
    output logic ee_load_valid,
    output logic [17:0] ee_load_word,
    output logic ee_present
);
    logic [3:0] rst_cnt_q;

    initial rst_cnt_q = 4'h0;

    // A pin reset is the only way the board gets fresh pin levels captured.
    always @(posedge aclk)
    begin
        if (rst_req)
            rst_cnt_q <= 4'h6;
        else if (rst_cnt_q != 4'h0)
            rst_cnt_q <= rst_cnt_q - 4'h1;
    end

    assign pin_resetn = (rst_cnt_q == 4'h0);
    assign ptp_enable_pin = ptp_level;
    assign hard_strap_pin = hard_level;
    assign ee_present = ee_attached;
    // The loader offers its image for as long as the device is still loading.
    assign ee_load_valid = ee_attached && !device_ready;
    assign ee_load_word = ee_load_valid ? ee_image : ~ee_image;
endmodule : csl_board_model

// *** csl_testbench.sv ***
// Purpose: Self-checking bench for the configuration strap latch.
// Assumes: Register offsets and field positions as chosen in the shared package.
// Notes: bready and rready stay high, so every answer is taken at the edge it appears.
`timescale 1ns/10ps
module testbench;
    logic aclk, aresetn, pin_resetn, ptp_enable_pin, hard_strap_pin, ee_load_valid, ee_present;
    logic [17:0] ee_load_word, ee_image;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic device_ready, crossover_mdix, ptp_level, hard_level, ee_attached, rst_req;
    logic [6:0] target_addr;
    int error_cnt = 0;
    int total_checks = 0;
    int cyc = 0;

    csl_strap_latch u_dut (.aclk(aclk), .aresetn(aresetn), .pin_resetn(pin_resetn),
        .ptp_enable_pin(ptp_enable_pin), .hard_strap_pin(hard_strap_pin), .ee_load_valid(ee_load_valid),
        .ee_load_word(ee_load_word), .ee_present(ee_present), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .device_ready(device_ready), .target_addr(target_addr),
        .crossover_mdix(crossover_mdix));

    csl_board_model u_board (.aclk(aclk), .device_ready(device_ready), .ptp_level(ptp_level),
        .hard_level(hard_level), .ee_attached(ee_attached), .ee_image(ee_image), .rst_req(rst_req),
        .pin_resetn(pin_resetn), .ptp_enable_pin(ptp_enable_pin), .hard_strap_pin(hard_strap_pin),
        .ee_load_valid(ee_load_valid), .ee_load_word(ee_load_word), .ee_present(ee_present));

    initial
    begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %08h expected %08h", $time, got, exp);
        end
    endtask : chk

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1 && !aw_ok)
            begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready === 1'b1 && !w_ok)
            begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        @(posedge aclk);
        while (s_axi_bvalid !== 1'b1)
            @(posedge aclk);
        chk({30'h0, s_axi_bresp}, {30'h0, csl_pkg::AXI_OKAY});
    endtask : axi_wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic bad);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        @(posedge aclk);
        while (s_axi_arready !== 1'b1)
            @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        @(posedge aclk);
        while (s_axi_rvalid !== 1'b1)
            @(posedge aclk);
        chk({30'h0, s_axi_rresp}, {30'h0, bad ? csl_pkg::AXI_SLVERR : csl_pkg::AXI_OKAY});
        if (!bad)
            chk(s_axi_rdata, exp);
    endtask : rd_chk

    // Bounded wait, so a ready line that never moves shows up as a mismatch.
    task automatic wait_ready(input logic lvl);
        int n;
        n = 0;
        while (device_ready !== lvl && n < 60)
        begin
            @(posedge aclk);
            n++;
        end
        chk({31'h0, device_ready}, {31'h0, lvl});
    endtask : wait_ready

    task automatic t_defaults;
        wait_ready(1'b1);
        rd_chk(8'h04, 32'h0000003F, 1'b0);
        rd_chk(8'h00, 32'h0004A143, 1'b0);
        rd_chk(8'h08, 32'h0000002A, 1'b0);
        chk({25'h0, target_addr}, {25'h0, csl_pkg::TGT_ADDR_BUILTIN});
        rd_chk(8'h0C, 32'h00000001, 1'b0);
        axi_wr(8'h0C, 32'h00000000);
        rd_chk(8'h0C, 32'h00000000, 1'b0);
        axi_wr(8'h10, 32'h00000000);
        rd_chk(8'h10, 32'h08000003, 1'b0);
        rd_chk(8'h40, 32'h0, 1'b1);
        $display("test defaults done");
    endtask : t_defaults

    task automatic t_eeprom;
        ee_image <= {1'b0, 1'b1, 7'h15, 3'h5, 6'h12};
        ee_attached <= 1'b1;
        rst_req <= 1'b1;
        @(posedge aclk);
        rst_req <= 1'b0;
        wait_ready(1'b0);
        wait_ready(1'b1);
        rd_chk(8'h04, 32'h00000512, 1'b0);
        rd_chk(8'h08, 32'h00000115, 1'b0);
        chk({25'h0, target_addr}, 32'h00000015);
        rd_chk(8'h10, 32'h08000001, 1'b0);
        rd_chk(8'h18, 32'h0000000E, 1'b0);
        axi_wr(8'h1C, 32'h00000001);
        chk({31'h0, crossover_mdix}, 32'h0);
        rd_chk(8'h1C, 32'h00000001, 1'b0);
        axi_wr(8'h1C, 32'h00000003);
        rd_chk(8'h1C, 32'h00000003, 1'b0);
        $display("test eeprom done");
    endtask : t_eeprom

    task automatic t_reload;
        ptp_level <= 1'b0;
        hard_level <= 1'b0;
        ee_attached <= 1'b0;
        axi_wr(8'h18, 32'h00000001);
        wait_ready(1'b0);
        wait_ready(1'b1);
        rd_chk(8'h04, 32'h0000003F, 1'b0);
        rd_chk(8'h08, 32'h0000002A, 1'b0);
        rd_chk(8'h0C, 32'h00000001, 1'b0);
        rd_chk(8'h10, 32'h08000003, 1'b0);
        rd_chk(8'h18, 32'h00000002, 1'b0);
        axi_wr(8'h14, 32'h00000001);
        wait_ready(1'b0);
        wait_ready(1'b1);
        rd_chk(8'h0C, 32'h00000001, 1'b0);
        $display("test reload done");
    endtask : t_reload

    task automatic t_pin_reset;
        rst_req <= 1'b1;
        @(posedge aclk);
        rst_req <= 1'b0;
        wait_ready(1'b0);
        wait_ready(1'b1);
        rd_chk(8'h0C, 32'h00000000, 1'b0);
        rd_chk(8'h10, 32'h08000002, 1'b0);
        $display("test pin reset done");
    endtask : t_pin_reset

    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : final_report

    // The whole run needs well under a thousand cycles.
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            error_cnt++;
            final_report();
        end
    end

    initial
    begin
        aresetn = 1'b0;
        ptp_level = 1'b1;
        hard_level = 1'b1;
        ee_attached = 1'b0;
        ee_image = 18'h00000;
        rst_req = 1'b0;
        s_axi_awaddr = 8'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h00000000;
        s_axi_wstrb = 4'h0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b1;
        s_axi_araddr = 8'h00;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b1;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_defaults();
        t_eeprom();
        t_reload();
        t_pin_reset();
        final_report();
    end
endmodule : testbench
